// ==== tio_pkg.sv ====
/*
 * Constants for the trigger input and status output block: register map,
 * field positions, reset values, mode encodings and timing counts.
 * Assumes a 20 MHz pclk and a 32-bit APB register bus.
 */
package tio_pkg;

	// ************************************************************
	// Clock and timing
	// ************************************************************
	localparam int CLK_HZ = 20_000_000;
	localparam int CYC_PER_US = CLK_HZ / 1_000_000;
	localparam int FILTER_TIME_US = 1000;
	localparam int FILTER_CYCLES = FILTER_TIME_US * CYC_PER_US;
	localparam int LONG_PULSE_TIME_MS = 1000;
	localparam int LONG_PULSE_CYCLES = LONG_PULSE_TIME_MS * 1000 * CYC_PER_US;

	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_OUTCMD = 8'h04;
	localparam logic [7:0] ADDR_STEP = 8'h08;
	localparam logic [7:0] ADDR_VREF = 8'h0C;
	localparam logic [7:0] ADDR_IREF = 8'h10;
	localparam logic [7:0] ADDR_VEXT = 8'h14;
	localparam logic [7:0] ADDR_IEXT = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1C;
	localparam logic [7:0] ADDR_CMD = 8'h20;

	// ************************************************************
	// Control register fields
	// ************************************************************
	localparam int CTRL_TRIG_LSB = 0;
	localparam int CTRL_STATUS_OUTPUT_ONE_LSB = 4;
	localparam int CTRL_STATUS_OUTPUT_TWO_LSB = 8;
	localparam int CTRL_SEQ_EN = 12;
	localparam int CTRL_MINMAX_EN = 13;
	localparam int CMD_SOFT_RESET = 0;
	localparam int CMD_EXT_RESET = 1;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [2:0] TRIG_RESET = 3'h0;
	localparam logic [3:0] SIG_RESET = 4'h0;
	localparam logic [7:0] STEP_START_RESET = 8'h0B;
	localparam logic [7:0] STEP_STOP_RESET = 8'hFF;
	localparam logic [15:0] REF_LO_RESET = 16'h0000;
	localparam logic [15:0] REF_HI_RESET = 16'hFFFF;

	// ************************************************************
	// Trigger function and status source encodings
	// ************************************************************
	typedef enum logic [2:0] {
		TRIG_OFF = 3'h0,
		TRIG_OUTPUT = 3'h1,
		TRIG_STEP = 3'h2,
		TRIG_SEQ = 3'h3,
		TRIG_LOCKOUT = 3'h4,
		TRIG_EXTREMES = 3'h5
	} tio_trig_e;

	typedef enum logic [3:0] {
		SIG_OFF = 4'h0,
		SIG_ON = 4'h1,
		SIG_OUT = 4'h2,
		SIG_MODE = 4'h3,
		SIG_SEQ = 4'h4,
		SIG_STEP = 4'h5,
		SIG_V_LO = 4'h6,
		SIG_V_HI = 4'h7,
		SIG_I_LO = 4'h8,
		SIG_I_HI = 4'h9
	} tio_sig_e;

endpackage

// ==== tio_top.sv ====
/*
 * Trigger input and status output logic of a programmable supply,
 * with an APB register slave. Holds the input filter, the trigger
 * functions and both status output drivers.
 * Assumes measured values, regulation state, trips, panel requests and
 * sequencer state arrive on pclk; the trigger pin is asynchronous.
 */
// The placing of the registers and register access over APB were chosen for this implementation.
// Operation
// - Trigger function off ignores the input
// - Act on input change within 15 ms
// - Gating, low: output follows manual or command
// - Gating, rising edge switches output off
// - Gating, high: output held off, requests refused
// - Gating, falling edge on unless trip
// - Pulse over 1 s reloads start address
// - Short pulse falling edge advances one step
// - Start to stop, then wrap to start
// - Sequence mode only with sequence enabled
// - Sequence mode: rising edge starts run
// - Sequence mode: falling edge jumps to stop
// - Lockout mode: high disables panel controls
// - Capture while low; rising edge freezes extremes
// - Falling edge loads extremes, resumes capture
// - Trigger selection kept by save and reset
// - Status outputs: off, on, output state
// - Regulation source: low on CC or overload; here only while the output is on
// - Sequence source: low while sequence runs
// - Step source: low during flagged step dwell
// - Threshold sources compare with references
// - Second output configured independently, same behaviour
`timescale 1ns/1ps

module tio_top
	import tio_pkg::*;
#(
	parameter int FILTER_CYC = FILTER_CYCLES,
	parameter int LONG_CYC = LONG_PULSE_CYCLES
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Isolated trigger pin
	input wire logic isolated_control_input,
	// Supply state
	input wire logic [15:0] meas_voltage,
	input wire logic [15:0] meas_current,
	input wire logic const_current,
	input wire logic power_overload,
	input wire logic overtemperature_trip,
	input wire logic overvoltage_trip,
	input wire logic panel_on_req,
	input wire logic panel_off_req,
	input wire logic seq_running,
	input wire logic step_signal_active,
	// Controls
	output logic power_output_on,
	output logic panel_lockout,
	output logic seq_start,
	output logic seq_stop_jump,
	output logic step_recall,
	output logic [7:0] step_address,
	output logic extremes_capture,
	// Status outputs, open collector, low is active
	output logic status_output_one_n,
	output logic status_output_two_n
);

	// ************************************************************
	// Functions
	// ************************************************************
	function automatic logic sig_active(input logic [3:0] sel,
		input logic out_on, input logic cc, input logic ovl,
		input logic run, input logic step, input logic v_lo,
		input logic v_hi, input logic i_lo, input logic i_hi);
		logic act;
		act = 1'b0;
		case (sel)
			SIG_OFF: act = 1'b0;
			SIG_ON: act = 1'b1;
			SIG_OUT: act = ~out_on;
			SIG_MODE: act = out_on & (cc | ovl);
			SIG_SEQ: act = run;
			SIG_STEP: act = step;
			SIG_V_LO: act = v_lo;
			SIG_V_HI: act = v_hi;
			SIG_I_LO: act = i_lo;
			SIG_I_HI: act = i_hi;
			default: act = 1'b0;
		endcase
		return act;
	endfunction

	// ************************************************************
	// Registers
	// ************************************************************
	logic [2:0] trig_sel_q;
	logic [3:0] status_output_one_sel_q, status_output_two_sel_q;
	logic seq_en_q, minmax_en_q;
	logic [7:0] start_q, stop_q;
	logic [15:0] vref_lo_q, vref_hi_q, iref_lo_q, iref_hi_q;
	logic [15:0] vmin_q, vmax_q, imin_q, imax_q;
	logic [1:0] sync_q;
	logic level_q, level_prev_q;
	logic [31:0] filt_cnt_q, high_cnt_q;
	logic long_done_q, primed_q;
	logic out_on_q, lockout_q, seq_start_q, seq_stop_q, recall_q;
	logic [7:0] addr_q;
	logic capture_q, status_output_one_n_q, status_output_two_n_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q;

	// ************************************************************
	// Bus decode
	// ************************************************************
	wire logic access = psel & penable & ~pready_q;
	wire logic wr = access & pwrite;
	wire logic hit_ctrl = paddr == ADDR_CTRL;
	wire logic hit_out = paddr == ADDR_OUTCMD;
	wire logic hit_step = paddr == ADDR_STEP;
	wire logic hit_vref = paddr == ADDR_VREF;
	wire logic hit_iref = paddr == ADDR_IREF;
	wire logic hit_vext = paddr == ADDR_VEXT;
	wire logic hit_iext = paddr == ADDR_IEXT;
	wire logic hit_stat = paddr == ADDR_STATUS;
	wire logic hit_cmd = paddr == ADDR_CMD;
	wire logic mapped = hit_ctrl | hit_out | hit_step | hit_vref |
		hit_iref | hit_vext | hit_iext | hit_stat | hit_cmd;
	wire logic soft_rst = wr & hit_cmd & pwdata[CMD_SOFT_RESET];
	wire logic ext_rst = wr & hit_cmd & pwdata[CMD_EXT_RESET];
	wire logic cmd_on = wr & hit_out & pwdata[0];
	wire logic cmd_off = wr & hit_out & ~pwdata[0];
	wire logic [31:0] status_word = {18'h0, addr_q, long_done_q,
		capture_q, lockout_q, out_on_q, level_q, sync_q[1]};
	wire logic [31:0] rd_word =
		hit_ctrl ? {18'h0, minmax_en_q, seq_en_q, status_output_two_sel_q,
			status_output_one_sel_q, 1'b0, trig_sel_q} :
		hit_out ? {31'h0, out_on_q} :
		hit_step ? {16'h0, stop_q, start_q} :
		hit_vref ? {vref_hi_q, vref_lo_q} :
		hit_iref ? {iref_hi_q, iref_lo_q} :
		hit_vext ? {vmax_q, vmin_q} :
		hit_iext ? {imax_q, imin_q} :
		hit_stat ? status_word : 32'h0;

	// ************************************************************
	// Trigger level and edges
	// ************************************************************
	// Only the filtered level is seen by the functions; the filter
	// window keeps the response inside the allowed delay
	wire logic sel_off = trig_sel_q == TRIG_OFF;
	wire logic rise = level_q & ~level_prev_q & ~sel_off;
	wire logic fall = ~level_q & level_prev_q & ~sel_off;
	wire logic high = level_q & ~sel_off;
	wire logic m_out = trig_sel_q == TRIG_OUTPUT;
	wire logic m_step = trig_sel_q == TRIG_STEP;
	wire logic m_seq = (trig_sel_q == TRIG_SEQ) & seq_en_q;
	wire logic m_lock = trig_sel_q == TRIG_LOCKOUT;
	wire logic m_ext = trig_sel_q == TRIG_EXTREMES;
	wire logic trip = overtemperature_trip | overvoltage_trip;
	wire logic long_hit = m_step & high & ~long_done_q &
		(high_cnt_q == 32'(LONG_CYC - 1));
	wire logic step_adv = m_step & fall & ~long_done_q;
	wire logic [7:0] next_addr =
		~primed_q ? start_q :
		(addr_q == stop_q) ? start_q : 8'(addr_q + 8'h01);

	// ************************************************************
	// Power output and lockout decisions
	// ************************************************************
	// Panel requests die while the panel is locked; a high gating
	// level refuses every on request until the falling edge
	wire logic lock_d = m_lock & high;
	wire logic pan_on = panel_on_req & ~lockout_q;
	wire logic pan_off = panel_off_req & ~lockout_q;
	wire logic gate_high = m_out & high;
	wire logic out_d =
		trip ? 1'b0 :
		(m_out & rise) ? 1'b0 :
		(m_out & fall) ? 1'b1 :
		gate_high ? 1'b0 :
		(cmd_off | pan_off) ? 1'b0 :
		(cmd_on | pan_on) ? 1'b1 :
		out_on_q;

	// ************************************************************
	// Extremes capture and threshold compare
	// ************************************************************
	wire logic cap_d = minmax_en_q & ~(m_ext & high);
	wire logic load_ext = (m_ext & fall) | ext_rst | soft_rst;
	wire logic v_lo = meas_voltage < vref_lo_q;
	wire logic v_hi = meas_voltage > vref_hi_q;
	wire logic i_lo = meas_current < iref_lo_q;
	wire logic i_hi = meas_current > iref_hi_q;
	wire logic status_output_one_d = sig_active(status_output_one_sel_q, out_on_q, const_current,
		power_overload, seq_running, step_signal_active,
		v_lo, v_hi, i_lo, i_hi);
	wire logic status_output_two_d = sig_active(status_output_two_sel_q, out_on_q, const_current,
		power_overload, seq_running, step_signal_active,
		v_lo, v_hi, i_lo, i_hi);

	// ************************************************************
	// APB slave
	// ************************************************************
	// One wait state: the answer comes in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= access;
			pslverr_q <= access & ~mapped;
			prdata_q <= (access & ~pwrite) ? rd_word : 32'h0;
		end
	end

	// ************************************************************
	// Configuration
	// ************************************************************
	// Soft reset restores settings but leaves the trigger selection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_sel_q <= TRIG_RESET;
		end else if (wr & hit_ctrl) begin
			trig_sel_q <= pwdata[CTRL_TRIG_LSB +: 3];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_output_one_sel_q <= SIG_RESET;
			status_output_two_sel_q <= SIG_RESET;
			seq_en_q <= 1'b0;
			minmax_en_q <= 1'b0;
			start_q <= STEP_START_RESET;
			stop_q <= STEP_STOP_RESET;
			vref_lo_q <= REF_LO_RESET;
			vref_hi_q <= REF_HI_RESET;
			iref_lo_q <= REF_LO_RESET;
			iref_hi_q <= REF_HI_RESET;
		end else if (soft_rst) begin
			status_output_one_sel_q <= SIG_RESET;
			status_output_two_sel_q <= SIG_RESET;
			seq_en_q <= 1'b0;
			minmax_en_q <= 1'b0;
			start_q <= STEP_START_RESET;
			stop_q <= STEP_STOP_RESET;
			vref_lo_q <= REF_LO_RESET;
			vref_hi_q <= REF_HI_RESET;
			iref_lo_q <= REF_LO_RESET;
			iref_hi_q <= REF_HI_RESET;
		end else if (wr) begin
			if (hit_ctrl) begin
				status_output_one_sel_q <= pwdata[CTRL_STATUS_OUTPUT_ONE_LSB +: 4];
				status_output_two_sel_q <= pwdata[CTRL_STATUS_OUTPUT_TWO_LSB +: 4];
				seq_en_q <= pwdata[CTRL_SEQ_EN];
				minmax_en_q <= pwdata[CTRL_MINMAX_EN];
			end
			if (hit_step) begin
				start_q <= pwdata[7:0];
				stop_q <= pwdata[15:8];
			end
			if (hit_vref) begin
				vref_lo_q <= pwdata[15:0];
				vref_hi_q <= pwdata[31:16];
			end
			if (hit_iref) begin
				iref_lo_q <= pwdata[15:0];
				iref_hi_q <= pwdata[31:16];
			end
		end
	end

	// ************************************************************
	// Input synchroniser and filter
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_q <= 2'b00;
			level_q <= 1'b0;
			level_prev_q <= 1'b0;
			filt_cnt_q <= 32'h0;
		end else begin
			sync_q <= {sync_q[0], isolated_control_input};
			level_prev_q <= level_q;
			if (sync_q[1] == level_q) begin
				filt_cnt_q <= 32'h0;
			end else if (filt_cnt_q == 32'(FILTER_CYC - 1)) begin
				filt_cnt_q <= 32'h0;
				level_q <= sync_q[1];
			end else begin
				filt_cnt_q <= filt_cnt_q + 32'h1;
			end
		end
	end

	// ************************************************************
	// Step recall
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			high_cnt_q <= 32'h0;
			long_done_q <= 1'b0;
			primed_q <= 1'b0;
			addr_q <= 8'h0;
			recall_q <= 1'b0;
		end else begin
			recall_q <= step_adv;
			high_cnt_q <= (m_step & high & ~long_done_q) ?
				high_cnt_q + 32'h1 : 32'h0;
			if (long_hit) begin
				long_done_q <= 1'b1;
				primed_q <= 1'b0;
				addr_q <= start_q;
			end else if (~high) begin
				long_done_q <= 1'b0;
			end
			if (step_adv) begin
				primed_q <= 1'b1;
				addr_q <= next_addr;
			end else if (soft_rst) begin
				primed_q <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Controls, extremes and status outputs
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_on_q <= 1'b0;
			lockout_q <= 1'b0;
			seq_start_q <= 1'b0;
			seq_stop_q <= 1'b0;
		end else begin
			out_on_q <= out_d;
			lockout_q <= lock_d;
			seq_start_q <= m_seq & rise;
			seq_stop_q <= m_seq & fall;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vmin_q <= 16'hFFFF;
			vmax_q <= 16'h0000;
			imin_q <= 16'hFFFF;
			imax_q <= 16'h0000;
			capture_q <= 1'b0;
			status_output_one_n_q <= 1'b1;
			status_output_two_n_q <= 1'b1;
		end else begin
			capture_q <= cap_d;
			status_output_one_n_q <= ~status_output_one_d;
			status_output_two_n_q <= ~status_output_two_d;
			if (load_ext) begin
				vmin_q <= meas_voltage;
				vmax_q <= meas_voltage;
				imin_q <= meas_current;
				imax_q <= meas_current;
			end else if (capture_q & cap_d) begin
				if (meas_voltage < vmin_q) vmin_q <= meas_voltage;
				if (meas_voltage > vmax_q) vmax_q <= meas_voltage;
				if (meas_current < imin_q) imin_q <= meas_current;
				if (meas_current > imax_q) imax_q <= meas_current;
			end
		end
	end

	// ************************************************************
	// Output drive
	// ************************************************************
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign power_output_on = out_on_q;
	assign panel_lockout = lockout_q;
	assign seq_start = seq_start_q;
	assign seq_stop_jump = seq_stop_q;
	assign step_recall = recall_q;
	assign step_address = addr_q;
	assign extremes_capture = capture_q;
	assign status_output_one_n = status_output_one_n_q;
	assign status_output_two_n = status_output_two_n_q;

endmodule

// ==== tio_properties.sv ====
/*
 * Concurrent checks on the ports of tio_top, bound to every instance.
 * Assumes one pclk domain and the active-low asynchronous presetn.
 */
`timescale 1ns/1ps

module tio_checker (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bus answer
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Trips and controls
	input wire logic overtemperature_trip,
	input wire logic overvoltage_trip,
	input wire logic power_output_on,
	input wire logic seq_start,
	input wire logic seq_stop_jump,
	input wire logic step_recall,
	input wire logic status_output_one_n,
	input wire logic status_output_two_n
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ************************************************************
	// Assertions
	// ************************************************************
	ready_one_cycle_a: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	rdata_idle_zero_a: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not zero outside answer");
	trip_forces_off_a: assert property (
		overtemperature_trip || overvoltage_trip |-> ##[1:2] !power_output_on)
		else $error("output still on during trip");
	on_needs_no_trip_a: assert property ($rose(power_output_on) |->
		!$past(overtemperature_trip) && !$past(overvoltage_trip))
		else $error("output switched on during trip");
	start_pulse_a: assert property (seq_start |=> !seq_start)
		else $error("sequence start longer than one cycle");
	recall_pulse_a: assert property (step_recall |=> !step_recall)
		else $error("step recall longer than one cycle");
	start_stop_excl_a: assert property (!(seq_start && seq_stop_jump))
		else $error("sequence start and stop together");
	reset_passive_a: assert property ($rose(presetn) |->
		status_output_one_n && status_output_two_n)
		else $error("status outputs active after reset");
endmodule

bind tio_top tio_checker chk_u (.pclk(pclk), .presetn(presetn),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.overtemperature_trip(overtemperature_trip),
	.overvoltage_trip(overvoltage_trip), .power_output_on(power_output_on),
	.seq_start(seq_start), .seq_stop_jump(seq_stop_jump),
	.step_recall(step_recall), .status_output_one_n(status_output_one_n),
	.status_output_two_n(status_output_two_n));

// ==== tio_trig_ctrl.sv ====
/*
 * External controller driving the isolated trigger pin.
 * Assumes it is called just after a rising pclk edge.
 */
`timescale 1ns/1ps

module tio_trig_ctrl (
	// Clock
	input wire logic pclk,
	// Trigger pin
	output logic trig
);
	initial trig = 1'b0;

	// Opto driver holds a level, it never floats
	task automatic drive(input logic v, input int hold);
		@(posedge pclk);
		trig <= v;
		repeat (hold) @(posedge pclk);
	endtask

	// Step pulse; width scaled like the short and long pulse windows
	task automatic pulse(input int width, input int gap);
		drive(1'b1, width);
		drive(1'b0, gap);
	endtask
endmodule

// ==== testbench.sv ====
/*
 * Self-checking bench for tio_top with short filter and pulse counts.
 * Assumes tio_checker is bound and tio_trig_ctrl drives the pin.
 */
`timescale 1ns/1ps

module testbench
	import tio_pkg::*;
;
	localparam int FC = 4;
	localparam int LC = 40;
	localparam int ST = FC + 8;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, trig, er;
	logic [7:0] paddr, saddr, last_addr;
	logic [31:0] pwdata, prdata, rd, vr, ir;
	logic [15:0] mv, mi;
	logic cc, ovl, otp, ovp, pon, poff, srun, ssig, on_e;
	logic out_on, lock, sstart, sstop, srcl, cap, s1_n, s2_n;
	logic [3:0] s1, s2;
	logic [7:0] ea [6];
	int mismatches, n_compared, n_start, n_stop, n_rcl, b, c;

	tio_top #(.FILTER_CYC(FC), .LONG_CYC(LC)) dut_u (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .isolated_control_input(trig),
		.meas_voltage(mv), .meas_current(mi), .const_current(cc),
		.power_overload(ovl), .overtemperature_trip(otp),
		.overvoltage_trip(ovp), .panel_on_req(pon), .panel_off_req(poff),
		.seq_running(srun), .step_signal_active(ssig),
		.power_output_on(out_on), .panel_lockout(lock), .seq_start(sstart),
		.seq_stop_jump(sstop), .step_recall(srcl), .step_address(saddr),
		.extremes_capture(cap), .status_output_one_n(s1_n),
		.status_output_two_n(s2_n));
	tio_trig_ctrl trig_u (.pclk(pclk), .trig(trig));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// Pulse counters; pulses stand one cycle only
	always @(posedge pclk) begin
		n_start += int'(sstart === 1'b1);
		n_stop += int'(sstop === 1'b1);
		if (srcl === 1'b1) begin
			n_rcl++;
			last_addr = saddr;
		end
	end

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("wait", 32'd2, n);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rdc(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask

	task automatic pin(input logic v);
		trig_u.drive(v, ST);
	endtask

	function automatic logic sig_n(input logic [3:0] s);
		case (s)
			SIG_ON: sig_n = 1'b0;
			SIG_OUT: sig_n = on_e;
			SIG_MODE: sig_n = !(on_e && (cc || ovl));
			SIG_SEQ: sig_n = !srun;
			SIG_STEP: sig_n = !ssig;
			SIG_V_LO: sig_n = !(mv < vr[15:0]);
			SIG_V_HI: sig_n = !(mv > vr[31:16]);
			SIG_I_LO: sig_n = !(mi < ir[15:0]);
			SIG_I_HI: sig_n = !(mi > ir[31:16]);
			default: sig_n = 1'b1;
		endcase
	endfunction

	task automatic conclude;
		$display("counts: %0d compared, %0d mismatched", n_compared,
			mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		conclude;
	end

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{mv, mi, cc, ovl, otp, ovp, pon, poff, srun, ssig} = '0;
		void'($urandom(32'hdd041b99));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc("ctrl", ADDR_CTRL, 32'h0);
		rdc("step", ADDR_STEP, {16'h0, STEP_STOP_RESET, STEP_START_RESET});
		rdc("vref", ADDR_VREF, {REF_HI_RESET, REF_LO_RESET});
		bus(1'b0, 8'h40, 32'hFFFF_FFFF);
		chk("slverr", 1'b1, er);
		chk("status_output_one", 1'b1, s1_n);
		wr(ADDR_OUTCMD, 32'h1);
		pin(1'b1);
		chk("off_hi", 1'b1, out_on);
		pin(1'b0);
		chk("off_lo", 1'b1, out_on);
		$display("test reset and off done");
		wr(ADDR_CTRL, TRIG_OUTPUT);
		pin(1'b1);
		chk("gate_rise", 1'b0, out_on);
		wr(ADDR_OUTCMD, 32'h1);
		pon <= 1'b1;
		@(posedge pclk);
		pon <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("gate_high", 1'b0, out_on);
		pin(1'b0);
		chk("gate_fall", 1'b1, out_on);
		poff <= 1'b1;
		@(posedge pclk);
		poff <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("gate_panel", 1'b0, out_on);
		wr(ADDR_OUTCMD, 32'h1);
		chk("gate_cmd", 1'b1, out_on);
		otp <= 1'b1;
		pin(1'b1);
		pin(1'b0);
		chk("gate_trip", 1'b0, out_on);
		otp <= 1'b0;
		$display("test gating done");
		ea = '{8'h20, 8'h21, 8'h22, 8'h20, 8'h20, 8'h20};
		wr(ADDR_STEP, 32'h2220);
		wr(ADDR_CTRL, TRIG_STEP);
		for (int k = 0; k < 6; k++) begin
			b = n_rcl;
			trig_u.pulse(k == 4 ? LC + 20 : FC + 6, ST);
			chk("rcl_cnt", b + int'(k != 4), n_rcl);
			if (k != 4) chk("rcl_addr", ea[k], last_addr);
			else chk("rcl_long", ea[4], saddr);
		end
		$display("test step done");
		b = n_start;
		c = n_stop;
		wr(ADDR_CTRL, TRIG_SEQ);
		pin(1'b1);
		pin(1'b0);
		chk("seq_off", b + c, n_start + n_stop);
		wr(ADDR_CTRL, 32'h1003);
		pin(1'b1);
		chk("seq_go", b + 1, n_start);
		pin(1'b0);
		chk("seq_end", c + 1, n_stop);
		wr(ADDR_CTRL, TRIG_LOCKOUT);
		pin(1'b1);
		chk("lock_hi", 1'b1, lock);
		pin(1'b0);
		chk("lock_lo", 1'b0, lock);
		$display("test sequence and lockout done");
		mv <= 16'h1234;
		wr(ADDR_CTRL, 32'h2005);
		chk("cap_lo", 1'b1, cap);
		pin(1'b1);
		chk("cap_hi", 1'b0, cap);
		pin(1'b0);
		chk("cap_fall", 1'b1, cap);
		rdc("vext", ADDR_VEXT, 32'h1234_1234);
		pin(1'b1);
		mv <= 16'h2345;
		rdc("vext_hold", ADDR_VEXT, 32'h1234_1234);
		pin(1'b0);
		$display("test extremes done");
		for (int k = 0; k < 40; k++) begin
			s1 = 4'($urandom_range(0, 9));
			s2 = 4'($urandom_range(0, 9));
			vr = {16'($urandom_range(0, 7)), 16'($urandom_range(0, 7))};
			ir = {16'($urandom_range(0, 7)), 16'($urandom_range(0, 7))};
			on_e = 1'($urandom);
			wr(ADDR_VREF, vr);
			wr(ADDR_IREF, ir);
			wr(ADDR_OUTCMD, {31'h0, on_e});
			wr(ADDR_CTRL, {20'h0, s2, s1, 4'h0});
			mv <= 16'($urandom_range(0, 7));
			mi <= 16'($urandom_range(0, 7));
			{cc, ovl, srun, ssig} <= 4'($urandom);
			repeat (3) @(posedge pclk);
			chk("status_output_one", sig_n(s1), s1_n);
			chk("status_output_two", sig_n(s2), s2_n);
		end
		$display("test status outputs done");
		wr(ADDR_CTRL, 32'h0274);
		wr(ADDR_CMD, 32'h1);
		rdc("ctrl_kept", ADDR_CTRL, 32'h4);
		$display("test soft reset done");
		conclude;
	end
endmodule
